// File: src/isqs_pkg.sv
// Shared constants, types and helpers of the input source qualify sequencer
package isqs_pkg;

  // Clock and timing
  localparam int CLK_MHZ        = 200;
  localparam int CYC_PER_MS     = CLK_MHZ * 1000;
  localparam int HOLDOFF_MS     = 250;
  localparam int HOLDOFF_CYC    = HOLDOFF_MS * CYC_PER_MS;
  localparam int CC_ATTACH_MS   = 150;
  localparam int CC_ATTACH_CYC  = CC_ATTACH_MS * CYC_PER_MS;
  localparam int CC_CHANGE_MS   = 15;
  localparam int CC_CHANGE_CYC  = CC_CHANGE_MS * CYC_PER_MS;
  localparam int DCD_MS         = 600;
  localparam int DCD_CYC        = DCD_MS * CYC_PER_MS;
  localparam int PHASE_MS       = 40;
  localparam int PHASE_CYC      = PHASE_MS * CYC_PER_MS;
  localparam int INT_PULSE_NS   = 1000;
  localparam int INT_PULSE_CYC  = INT_PULSE_NS * CLK_MHZ / 1000;

  // Register map (byte addresses)
  localparam int          ADDR_W    = 4;
  localparam logic [3:0]  REG_CTRL  = 4'h0;
  localparam logic [3:0]  REG_STAT  = 4'h4;
  localparam logic [3:0]  REG_CAP   = 4'h8;
  localparam logic [3:0]  REG_FLOOR = 4'hC;

  // Input current cap in 100mA steps, floor in mV
  localparam logic [5:0]  CAP_500   = 6'h05;
  localparam logic [5:0]  CAP_1A    = 6'h0A;
  localparam logic [5:0]  CAP_1P5   = 6'h0F;
  localparam logic [5:0]  CAP_2A    = 6'h14;
  localparam logic [5:0]  CAP_2P1   = 6'h15;
  localparam logic [5:0]  CAP_2P4   = 6'h18;
  localparam logic [5:0]  CAP_3A    = 6'h1E;
  localparam logic [5:0]  CAP_RST   = CAP_500;
  localparam logic [12:0] FLOOR_RST = 13'h1108;
  localparam logic [13:0] TRACK_MV  = 14'h00A5;

  typedef enum logic [3:0] {
    PT_NONE = 4'h0, PT_SDP = 4'h1, PT_DCP = 4'h2, PT_CDP = 4'h3,
    PT_DIV1 = 4'h4, PT_DIV2 = 4'h5, PT_DIV3 = 4'h6, PT_DIV4 = 4'h7,
    PT_DIV5 = 4'h8, PT_UNK = 4'h9
  } isqs_port_t;

  // CC comparator class, ordered by capability
  typedef enum logic [1:0] {CC_RA = 2'h0, CC_DEF = 2'h1, CC_1P5 = 2'h2, CC_3A = 2'h3} isqs_cc_t;

  // D+/D- comparator window class
  typedef enum logic [2:0] {
    WIN_NONE = 3'h0, WIN_1P2 = 3'h1, WIN_2P0 = 3'h2, WIN_2P7 = 3'h3, WIN_ABOVE = 3'h4
  } isqs_win_t;

  typedef enum logic [1:0] {PH_IDLE = 2'h0, PH_DCD = 2'h1, PH_PRI = 2'h2, PH_SEC = 2'h3} isqs_phase_t;

  typedef enum {ST_WAIT_VIN, ST_HOLDOFF, ST_DET_GATE, ST_DCD, ST_PRIMARY, ST_SECONDARY,
                ST_NONSTD, ST_DONE} isqs_state_t;

  // Control register, bit 0 is chg_en
  typedef struct packed {
    logic lpv_mask;
    logic lpc_mask;
    logic bsw_off;
    logic restart;
    logic track;
    logic tc_en;
    logic auto_en;
    logic delay_en;
    logic buck_en;
    logic chg_en;
  } isqs_ctrl_t;
  localparam logic [9:0] CTRL_RST = 10'h01F;

  // Asynchronous analog comparator and pin inputs
  typedef struct packed {
    logic      vin_window;
    logic      vin_good;
    logic      batt_ok;
    logic      batt_ocp;
    logic      ntc_ok;
    logic      dcd_contact;
    logic      primary_hit;
    logic      secondary_hit;
    logic      loop_cur;
    logic      loop_vol;
    logic      sys_min;
    isqs_win_t dp;
    isqs_win_t dm;
    isqs_cc_t  cca;
    isqs_cc_t  ccb;
  } isqs_pins_t;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
  } isqs_avs_req_t;

  typedef struct packed {
    isqs_pins_t  s1;
    isqs_pins_t  s2;
    isqs_pins_t  s3;
    isqs_pins_t  filt;
    isqs_state_t st;
    logic [31:0] tmr;
    logic [31:0] cc_tmr;
    isqs_cc_t    cc_cand;
    isqs_cc_t    cc_acc;
    isqs_ctrl_t  ctrl;
    isqs_port_t  port;
    isqs_cc_t    cca;
    isqs_cc_t    ccb;
    logic [5:0]  cap;
    logic [12:0] floor;
    logic        qualified;
    logic        vin_q;
    logic        lpc_q;
    logic        lpv_q;
    logic        ev_pend;
    logic [15:0] int_cnt;
    logic        int_oe_n;
    logic        waitreq;
    logic [31:0] rdata;
    logic        conv_on;
    logic        chg_on;
    logic        bsw_on;
    logic [13:0] floor_o;
    isqs_phase_t phase;
  } isqs_regs_t;

  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
                                       input logic [3:0] be);
    wr16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic [5:0] cap_of_port(input isqs_port_t pt);
    case (pt)
      PT_DCP:  cap_of_port = CAP_2A;
      PT_CDP:  cap_of_port = CAP_1P5;
      PT_DIV1: cap_of_port = CAP_1A;
      PT_DIV2: cap_of_port = CAP_2P1;
      PT_DIV3: cap_of_port = CAP_2P4;
      PT_DIV4: cap_of_port = CAP_2A;
      PT_DIV5: cap_of_port = CAP_3A;
      default: cap_of_port = CAP_500;
    endcase
  endfunction

  function automatic logic [5:0] cap_select(input isqs_cc_t cc, input logic tc_en,
                                            input logic auto_en, input isqs_port_t pt);
    if (!tc_en || cc == CC_DEF) begin
      cap_select = auto_en ? cap_of_port(pt) : CAP_500;
    end else begin
      case (cc)
        CC_1P5:  cap_select = CAP_1P5;
        CC_3A:   cap_select = CAP_3A;
        default: cap_select = CAP_500;
      endcase
    end
  endfunction

  function automatic isqs_port_t classify_div(input isqs_win_t dp, input isqs_win_t dm);
    if (dp == WIN_2P0 && dm == WIN_2P7) begin
      classify_div = PT_DIV1;
    end else if (dp == WIN_2P7 && dm == WIN_2P0) begin
      classify_div = PT_DIV2;
    end else if (dp == WIN_2P7 && dm == WIN_2P7) begin
      classify_div = PT_DIV3;
    end else if (dp == WIN_1P2 && dm == WIN_1P2) begin
      classify_div = PT_DIV4;
    end else if (dp == WIN_2P7 && dm == WIN_ABOVE) begin
      classify_div = PT_DIV5;
    end else begin
      classify_div = PT_UNK;
    end
  endfunction

endpackage

// File: src/isqs_top.sv
// Input source qualify sequencer with Avalon-MM register slave
//
// Chosen here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
// Notes on behaviour
// - At supply power-up all registers take defaults before the bus answers.
// - No input and battery healthy: battery switch turns on.
// - Battery overcurrent turns switch off at once and sets switch-off bit.
// - Attach order: input seen, hold-off, detect, cap, converter, charging.
// - Hold-off enable at zero skips hold-off.
// - Detection needs input in window, input good, hold-off done, auto or restart.
// - Contact detect first, then primary/secondary; contact timeout runs divider check.
// - Divider types one to five from D+ and D- window classes.
// - Auto detect off: detection bypassed, port result stays 0000.
// - Port result maps to current cap per fixed table.
// - Each CC line classed as default, 1.5A or 3A sink sub-state.
// - Detection end updates CC results, port result, cap, sets qualified.
// - Qualified set comes with an event pulse and cap update.
// - Restart bit reruns detection, updates result and cap, pulses event.
// - CC change stable 15ms updates cap and pulses event.
// - Final cap from CC 1.5A/3A sub-state, port result on default sub-state, else 500mA.
// - Voltage floor is register, or max with battery plus 165mV when tracking.
// - Converter starts only when qualified and converter enabled.
// - Loop-active status bits set while in loop, with maskable event.
// - Charging needs converter on, thermistors fine, switch-off clear, charge enabled.
// - Status bit shows system held at minimum regulation point.
// - CC attach debounced 150ms before sub-state is valid.
module isqs_top
  import isqs_pkg::*;
#(
  parameter int HOLDOFF_CYC_P   = HOLDOFF_CYC,
  parameter int DCD_CYC_P       = DCD_CYC,
  parameter int PHASE_CYC_P     = PHASE_CYC,
  parameter int CC_ATTACH_CYC_P = CC_ATTACH_CYC,
  parameter int CC_CHANGE_CYC_P = CC_CHANGE_CYC,
  parameter int INT_PULSE_CYC_P = INT_PULSE_CYC
) (
  // Clock, reset, enable
  input  wire logic          clock_in,
  input  wire logic          rst_n_in,
  input  wire logic          ce_in,
  // Avalon-MM slave
  input  wire isqs_avs_req_t avs_req_in,
  output logic [31:0]        avs_readdata_out,
  output logic               avs_waitrequest_out,
  // Comparator and pin inputs, asynchronous
  input  wire isqs_pins_t    pins_in,
  // Battery voltage in mV, same clock
  input  wire logic [12:0]   vbatt_mv_in,
  // Power path controls
  output logic               converter_start_out,
  output logic               charge_start_out,
  output logic               battery_switch_out,
  output logic [5:0]         input_current_cap_out,
  output logic [13:0]        input_voltage_floor_out,
  output isqs_phase_t        det_phase_out,
  // Open-drain event line
  output logic               int_o_out,
  output logic               int_oe_n_out
);

  isqs_regs_t r;
  isqs_regs_t n;
  isqs_pins_t f;
  logic       vin_ok;
  logic       wr;

  assign f      = r.filt;
  assign vin_ok = f.vin_window & f.vin_good;
  assign wr     = avs_req_in.write & ~r.waitreq;

  always_comb begin
    logic       ev;
    logic       done;
    isqs_port_t pt;
    isqs_cc_t   cc_raw;
    logic [31:0] cc_lim;
    logic [15:0] w16;
    logic        ctrl_wr;
    ev     = 1'b0;
    done   = 1'b0;
    pt     = r.port;
    cc_raw = (f.cca > f.ccb) ? f.cca : f.ccb;
    cc_lim = '0;
    w16    = '0;
    ctrl_wr = wr && (avs_req_in.address == REG_CTRL);
    n      = r;

    // Change accepted only once second and third stage agree
    n.s1   = pins_in;
    n.s2   = r.s1;
    n.s3   = r.s2;
    n.filt = isqs_pins_t'((r.s3 & ~(r.s2 ^ r.s3)) | (r.filt & (r.s2 ^ r.s3)));

    // Bus: one wait cycle, then answer
    n.waitreq = 1'b1;
    if ((avs_req_in.read | avs_req_in.write) && r.waitreq) begin
      n.waitreq = 1'b0;
      n.rdata   = '0;
      if (avs_req_in.read) begin
        case (avs_req_in.address)
          REG_CTRL:  n.rdata = {22'h000000, r.ctrl};
          REG_STAT:  n.rdata = {16'h0000, r.ccb, r.cca, r.port, r.bsw_on, r.chg_on, r.conv_on,
                                f.sys_min, f.loop_vol, f.loop_cur, r.qualified, f.vin_good};
          REG_CAP:   n.rdata = {26'h0000000, r.cap};
          REG_FLOOR: n.rdata = {19'h00000, r.floor};
          default:   n.rdata = '0;
        endcase
      end
    end
    if (wr) begin
      case (avs_req_in.address)
        REG_CTRL: begin
          w16    = wr16({6'h00, r.ctrl}, avs_req_in.writedata, avs_req_in.byteenable);
          n.ctrl = isqs_ctrl_t'(w16[9:0]);
        end
        REG_CAP: begin
          w16   = wr16({10'h000, r.cap}, avs_req_in.writedata, avs_req_in.byteenable);
          n.cap = w16[5:0];
        end
        REG_FLOOR: begin
          w16     = wr16({3'h0, r.floor}, avs_req_in.writedata, avs_req_in.byteenable);
          n.floor = w16[12:0];
        end
        default: n.cap = r.cap;
      endcase
    end

    // Fresh attach wakes the switch; overcurrent set wins over any clear
    n.vin_q = vin_ok;
    if (vin_ok && !r.vin_q) begin
      n.ctrl.bsw_off = 1'b0;
    end
    if (f.batt_ocp) begin
      n.ctrl.bsw_off = 1'b1;
    end

    case (r.st)
      ST_WAIT_VIN: begin
        n.tmr = '0;
        if (vin_ok) begin
          n.st = r.ctrl.delay_en ? ST_HOLDOFF : ST_DET_GATE;
        end
      end
      ST_HOLDOFF: begin
        n.tmr = r.tmr + 32'h1;
        if (r.tmr >= 32'(HOLDOFF_CYC_P - 1)) begin
          n.st = ST_DET_GATE;
        end
      end
      ST_DET_GATE: begin
        n.tmr = '0;
        if (r.ctrl.auto_en || r.ctrl.restart) begin
          // Host restart written in this cycle survives the clear
          n.ctrl.restart = n.ctrl.restart & ctrl_wr;
          n.st           = ST_DCD;
        end else begin
          pt   = PT_NONE;
          done = 1'b1;
        end
      end
      ST_DCD: begin
        n.tmr = r.tmr + 32'h1;
        // contact then BC1.2, else divider check
        if (f.dcd_contact) begin
          n.tmr = '0;
          n.st  = ST_PRIMARY;
        end else if (r.tmr >= 32'(DCD_CYC_P - 1)) begin
          n.st = ST_NONSTD;
        end
      end
      ST_PRIMARY: begin
        n.tmr = r.tmr + 32'h1;
        if (r.tmr >= 32'(PHASE_CYC_P - 1)) begin
          n.tmr = '0;
          if (f.primary_hit) begin
            n.st = ST_SECONDARY;
          end else begin
            pt   = PT_SDP;
            done = 1'b1;
          end
        end
      end
      ST_SECONDARY: begin
        n.tmr = r.tmr + 32'h1;
        if (r.tmr >= 32'(PHASE_CYC_P - 1)) begin
          pt   = f.secondary_hit ? PT_DCP : PT_CDP;
          done = 1'b1;
        end
      end
      ST_NONSTD: begin
        pt   = classify_div(f.dp, f.dm);
        done = 1'b1;
      end
      ST_DONE: begin
        if (r.ctrl.restart) begin
          n.ctrl.restart = n.ctrl.restart & ctrl_wr;
          n.tmr          = '0;
          n.st           = ST_DCD;
        end
      end
      default: n.st = ST_WAIT_VIN;
    endcase

    if (done) begin
      n.st        = ST_DONE;
      n.port      = pt;
      n.cca       = f.cca;
      n.ccb       = f.ccb;
      n.qualified = 1'b1;
      n.cap = cap_select(r.cc_acc, r.ctrl.tc_en, r.ctrl.auto_en, pt);
      ev = 1'b1;
    end

    // comparator class, attach debounce, change debounce
    cc_lim = (r.cc_acc == CC_RA) ? 32'(CC_ATTACH_CYC_P - 1) : 32'(CC_CHANGE_CYC_P - 1);
    if (cc_raw != r.cc_cand) begin
      n.cc_cand = cc_raw;
      n.cc_tmr  = '0;
    end else if (r.cc_tmr < cc_lim) begin
      n.cc_tmr = r.cc_tmr + 32'h1;
    end else if (r.cc_cand != r.cc_acc) begin
      n.cc_acc = r.cc_cand;
      if (r.qualified && !done && r.ctrl.tc_en) begin
        n.cca = f.cca;
        n.ccb = f.ccb;
        n.cap = cap_select(r.cc_cand, r.ctrl.tc_en, r.ctrl.auto_en, r.port);
        ev    = 1'b1;
      end
    end

    n.lpc_q = f.loop_cur;
    n.lpv_q = f.loop_vol;
    if ((f.loop_cur && !r.lpc_q && !r.ctrl.lpc_mask) || (f.loop_vol && !r.lpv_q && !r.ctrl.lpv_mask)) begin
      ev = 1'b1;
    end

    if (!vin_ok) begin
      n.st        = ST_WAIT_VIN;
      n.qualified = 1'b0;
      n.tmr       = '0;
    end

    // fixed pulse; one event queued while a pulse runs
    if (r.int_cnt != 16'h0000) begin
      n.int_cnt = r.int_cnt - 16'h0001;
      n.ev_pend = r.ev_pend | ev;
    end else if (ev || r.ev_pend) begin
      n.int_cnt = 16'(INT_PULSE_CYC_P);
      n.ev_pend = 1'b0;
    end
    n.int_oe_n = (n.int_cnt == 16'h0000);

    n.conv_on = r.qualified & r.ctrl.buck_en & vin_ok;
    n.chg_on  = r.conv_on & f.ntc_ok & ~r.ctrl.bsw_off & r.ctrl.chg_en;
    n.bsw_on  = ~n.ctrl.bsw_off & (vin_ok ? r.conv_on : f.batt_ok);
    if (r.ctrl.track && (14'(vbatt_mv_in) + TRACK_MV > {1'b0, r.floor})) begin
      n.floor_o = 14'(vbatt_mv_in) + TRACK_MV;
    end else begin
      n.floor_o = {1'b0, r.floor};
    end

    case (r.st)
      ST_DCD:       n.phase = PH_DCD;
      ST_PRIMARY:   n.phase = PH_PRI;
      ST_SECONDARY: n.phase = PH_SEC;
      default:      n.phase = PH_IDLE;
    endcase
  end

  // defaults at power-up; bus stalls until then
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      r          <= '0;
      r.ctrl     <= isqs_ctrl_t'(CTRL_RST);
      r.cap      <= CAP_RST;
      r.floor    <= FLOOR_RST;
      r.floor_o  <= {1'b0, FLOOR_RST};
      r.waitreq  <= 1'b1;
      r.int_oe_n <= 1'b1;
    end else if (ce_in) begin
      r <= n;
    end
  end

  assign avs_readdata_out        = r.rdata;
  assign avs_waitrequest_out     = r.waitreq;
  assign converter_start_out     = r.conv_on;
  assign charge_start_out        = r.chg_on;
  assign battery_switch_out      = r.bsw_on;
  assign input_current_cap_out   = r.cap;
  assign input_voltage_floor_out = r.floor_o;
  assign det_phase_out           = r.phase;
  assign int_o_out               = 1'b0;
  assign int_oe_n_out            = r.int_oe_n;

  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  property p_ocp_off;
    (ce_in && f.batt_ocp) |=> (r.ctrl.bsw_off && !battery_switch_out);
  endproperty
  a_ocp_off: assert property (p_ocp_off) else $error("overcurrent did not open switch");

  property p_skip_holdoff;
    (ce_in && r.st == ST_WAIT_VIN && vin_ok && !r.ctrl.delay_en) |=> r.st != ST_HOLDOFF;
  endproperty
  a_skip_holdoff: assert property (p_skip_holdoff) else $error("hold-off not skipped");

  property p_bypass_zero;
    ($rose(r.qualified) && !r.ctrl.auto_en && $past(r.st) == ST_DET_GATE) |-> r.port == PT_NONE;
  endproperty
  a_bypass_zero: assert property (p_bypass_zero) else $error("bypass result not zero");

  property p_qual_event;
    $rose(r.qualified) |-> ##[0:2] !int_oe_n_out;
  endproperty
  a_qual_event: assert property (p_qual_event) else $error("no event on qualification");

  property p_conv_gate;
    (ce_in && !r.qualified) |=> !converter_start_out;
  endproperty
  a_conv_gate: assert property (p_conv_gate) else $error("converter started unqualified");

  property p_charge_gate;
    $rose(charge_start_out) |-> $past(converter_start_out) && !$past(r.ctrl.bsw_off);
  endproperty
  a_charge_gate: assert property (p_charge_gate) else $error("charge started early");

  property p_floor_min;
    input_voltage_floor_out >= {1'b0, $past(r.floor, 2)} || $past(r.floor) != $past(r.floor, 2);
  endproperty
  a_floor_min: assert property (p_floor_min) else $error("floor below register");

  property p_pulse_width;
    $fell(int_oe_n_out) |-> !int_oe_n_out [*8];
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("event pulse too short");

  property p_removal;
    (ce_in && !vin_ok) |=> (!r.qualified && r.st == ST_WAIT_VIN);
  endproperty
  a_removal: assert property (p_removal) else $error("removal did not abort");

  property p_battery_on;
    (ce_in && !vin_ok && f.batt_ok && !f.batt_ocp && !r.ctrl.bsw_off && !wr) |=> battery_switch_out;
  endproperty
  a_battery_on: assert property (p_battery_on) else $error("battery switch not on");

  property p_gate_bypass;
    (ce_in && r.st == ST_DET_GATE && !r.ctrl.auto_en && !r.ctrl.restart) |=> r.st != ST_DCD;
  endproperty
  a_gate_bypass: assert property (p_gate_bypass) else $error("detection ran while disabled");

  property p_restart_run;
    (ce_in && r.st == ST_DONE && r.ctrl.restart && vin_ok) |=> r.st == ST_DCD;
  endproperty
  a_restart_run: assert property (p_restart_run) else $error("restart did not rerun detection");

endmodule

// File: testbench/isqs_adapter_model.sv
// Behavioural USB adapter seen on D+/D- and CC
`timescale 1ns/1ps
module isqs_adapter_model
  import isqs_pkg::*;
(
  // Clock and plug state
  input  wire logic       clock_in,
  input  wire logic       attach_in,
  input  wire isqs_port_t kind_in,
  input  wire isqs_cc_t   cc_in,
  input  wire logic       slow_in,
  // Line classes
  output logic            contact_out,
  output logic            primary_out,
  output logic            secondary_out,
  output isqs_win_t       dp_out,
  output isqs_win_t       dm_out,
  output isqs_cc_t        cca_out,
  output isqs_cc_t        ccb_out
);
  logic [3:0] age_r;
  logic       std;
  always_ff @(posedge clock_in) begin
    age_r <= !attach_in ? 4'h0 : (age_r == 4'hF ? age_r : age_r + 4'h1);
  end
  // Slow mode mimics a plug whose data pins touch late
  always_comb begin
    std = kind_in inside {PT_SDP, PT_DCP, PT_CDP};
    contact_out = attach_in && std && age_r >= (slow_in ? 4'hC : 4'h2);
    primary_out = contact_out && kind_in != PT_SDP;
    secondary_out = contact_out && kind_in == PT_DCP;
    dp_out = WIN_NONE;
    dm_out = WIN_NONE;
    if (attach_in) begin
      case (kind_in)
        PT_DIV1: begin
          dp_out = WIN_2P0;
          dm_out = WIN_2P7;
        end
        PT_DIV2: begin
          dp_out = WIN_2P7;
          dm_out = WIN_2P0;
        end
        PT_DIV3: begin
          dp_out = WIN_2P7;
          dm_out = WIN_2P7;
        end
        PT_DIV4: begin
          dp_out = WIN_1P2;
          dm_out = WIN_1P2;
        end
        PT_DIV5: begin
          dp_out = WIN_2P7;
          dm_out = WIN_ABOVE;
        end
        default: ;
      endcase
    end
    cca_out = cc_in;
    ccb_out = CC_RA;
  end
endmodule

// File: testbench/tb.sv
// Self-checking bench of the input source qualify sequencer
`timescale 1ns/1ps
module tb;
  import isqs_pkg::*;
  logic          clock_in;
  logic          rst_n_in;
  logic          ce_in;
  isqs_avs_req_t req;
  logic [31:0]   rdata;
  logic          wreq;
  isqs_pins_t    p;
  isqs_pins_t    pw;
  logic [12:0]   vbatt;
  logic          conv;
  logic          chg;
  logic          bsw;
  logic [5:0]    cap;
  logic [13:0]   floor_mv;
  logic          oe_n;
  isqs_phase_t   ph;
  isqs_port_t    kind;
  isqs_cc_t      cc;
  logic          slow;
  logic          m_c;
  logic          m_p;
  logic          m_s;
  isqs_win_t     m_dp;
  isqs_win_t     m_dm;
  isqs_cc_t      m_a;
  isqs_cc_t      m_b;
  int            fails;
  int            check_count;
  int            cyc = 0;
  int            n;
  logic [31:0]   q;
  isqs_port_t    kinds [8] = '{PT_SDP, PT_CDP, PT_DIV1, PT_DIV2, PT_DIV3, PT_DIV4, PT_DIV5, PT_UNK};
  logic [5:0]    caps [8] = '{6'h05, 6'h0F, 6'h0A, 6'h15, 6'h18, 6'h14, 6'h1E, 6'h05};
  isqs_cc_t      ccs [4] = '{CC_3A, CC_1P5, CC_RA, CC_DEF};
  logic [5:0]    cccap [4] = '{6'h1E, 6'h0F, 6'h05, 6'h14};
  int            cclo [4] = '{8, 8, 8, 20};

  always #2.5 clock_in = ~clock_in;

  always_comb begin
    pw = p;
    pw.dcd_contact = m_c;
    pw.primary_hit = m_p;
    pw.secondary_hit = m_s;
    pw.dp = m_dp;
    pw.dm = m_dm;
    pw.cca = m_a;
    pw.ccb = m_b;
  end

  isqs_top #(
    .HOLDOFF_CYC_P  (20),
    .DCD_CYC_P      (30),
    .PHASE_CYC_P    (10),
    .CC_ATTACH_CYC_P(20),
    .CC_CHANGE_CYC_P(8)
  ) dut (
    .clock_in               (clock_in),
    .rst_n_in               (rst_n_in),
    .ce_in                  (ce_in),
    .avs_req_in             (req),
    .avs_readdata_out       (rdata),
    .avs_waitrequest_out    (wreq),
    .pins_in                (pw),
    .vbatt_mv_in            (vbatt),
    .converter_start_out    (conv),
    .charge_start_out       (chg),
    .battery_switch_out     (bsw),
    .input_current_cap_out  (cap),
    .input_voltage_floor_out(floor_mv),
    .det_phase_out          (ph),
    .int_o_out              (),
    .int_oe_n_out           (oe_n)
  );

  isqs_adapter_model adapter (
    .clock_in     (clock_in),
    .attach_in    (p.vin_window),
    .kind_in      (kind),
    .cc_in        (cc),
    .slow_in      (slow),
    .contact_out  (m_c),
    .primary_out  (m_p),
    .secondary_out(m_s),
    .dp_out       (m_dp),
    .dm_out       (m_dm),
    .cca_out      (m_a),
    .ccb_out      (m_b)
  );

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Holds the request until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    req.read <= !w;
    req.write <= w;
    req.address <= a;
    req.writedata <= d;
    req.byteenable <= 4'hF;
    do begin
      @(posedge clock_in);
    end while (wreq !== 1'b0);
    q = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge clock_in);
  endtask

  task automatic ev(input int lo, input int hi);
    int w;
    n = 0;
    while (oe_n !== 1'b0 && n < 400) begin
      @(posedge clock_in);
      n++;
    end
    chk("event delay", 1, 32'(n >= lo && n < hi));
    w = 0;
    while (oe_n === 1'b0) begin
      @(posedge clock_in);
      w++;
    end
    chk("pulse width", 32'(INT_PULSE_CYC), 32'(w));
  endtask

  task automatic plug(input logic on);
    p.vin_window <= on;
    p.vin_good <= on;
    if (!on) begin
      repeat (10) @(posedge clock_in);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    clock_in = 1'b0;
    rst_n_in = 1'b0;
    ce_in = 1'b1;
    req = '0;
    p = '0;
    p.batt_ok = 1'b1;
    p.ntc_ok = 1'b1;
    vbatt = 13'h0FA0;
    kind = PT_DCP;
    cc = CC_DEF;
    slow = 1'b1;
    fails = 0;
    check_count = 0;
    repeat (6) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (6) @(posedge clock_in);
    chk("battery switch", 1, 32'(bsw));
    bus(0, REG_CTRL, 0);
    chk("ctrl default", 32'h01F, q);
    bus(0, REG_CAP, 0);
    chk("cap default", 32'h05, q);
    bus(0, REG_FLOOR, 0);
    chk("floor default", 32'h1108, q);
    bus(0, 4'h1, 0);
    chk("unmapped", 0, q);
    // Overcurrent trips the switch, host clears it after
    p.batt_ocp <= 1'b1;
    repeat (6) @(posedge clock_in);
    chk("switch trip", 0, 32'(bsw));
    bus(0, REG_CTRL, 0);
    chk("switch off bit", 32'h09F, q);
    p.batt_ocp <= 1'b0;
    repeat (6) @(posedge clock_in);
    bus(1, REG_CTRL, 32'h00F);
    repeat (6) @(posedge clock_in);
    chk("switch back", 1, 32'(bsw));
    plug(1);
    ev(20, 400);
    bus(0, REG_STAT, 0);
    chk("dcp result", 32'h2, 32'(q[11:8]));
    chk("dcp cap", 32'h14, 32'(cap));
    chk("converter", 1, 32'(conv));
    chk("charging", 1, 32'(chg));
    bus(1, REG_CTRL, 32'h00E);
    repeat (3) @(posedge clock_in);
    chk("charge gated", 0, 32'(chg));
    bus(1, REG_CTRL, 32'h00B);
    slow <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      plug(0);
      chk("converter off", 0, 32'(conv));
      bus(0, REG_STAT, 0);
      chk("qualified off", 0, 32'(q[1]));
      kind <= kinds[i];
      plug(1);
      ev(0, i == 0 ? 28 : 400);
      bus(0, REG_STAT, 0);
      chk("port result", 32'(kinds[i]), 32'(q[11:8]));
      chk("port cap", 32'(caps[i]), 32'(cap));
    end
    plug(0);
    bus(1, REG_CTRL, 32'h003);
    kind <= PT_DCP;
    plug(1);
    ev(0, 400);
    bus(0, REG_STAT, 0);
    chk("bypass result", 0, 32'(q[11:8]));
    chk("bypass cap", 32'h05, 32'(cap));
    plug(0);
    bus(1, REG_CTRL, 32'h01B);
    plug(1);
    ev(0, 400);
    for (int i = 0; i < 4; i++) begin
      cc <= ccs[i];
      ev(cclo[i], 400);
      chk("cc cap", 32'(cccap[i]), 32'(cap));
      bus(0, REG_STAT, 0);
      chk("cc result", 32'(ccs[i]), 32'(q[13:12]));
    end
    bus(1, REG_CAP, 32'h0A);
    chk("host cap", 32'h0A, 32'(cap));
    bus(1, REG_CTRL, 32'h05B);
    repeat (4) @(posedge clock_in);
    chk("primary phase", 32'(PH_PRI), 32'(ph));
    ev(0, 400);
    chk("restart cap", 32'h14, 32'(cap));
    bus(1, REG_FLOOR, 32'h1000);
    bus(1, REG_CTRL, 32'h03B);
    repeat (3) @(posedge clock_in);
    chk("floor tracked", 32'h1045, 32'(floor_mv));
    bus(1, REG_CTRL, 32'h01B);
    repeat (3) @(posedge clock_in);
    chk("floor fixed", 32'h1000, 32'(floor_mv));
    p.loop_cur <= 1'b1;
    ev(0, 400);
    bus(0, REG_STAT, 0);
    chk("current loop", 1, 32'(q[2]));
    bus(1, REG_CTRL, 32'h21B);
    p.loop_vol <= 1'b1;
    p.sys_min <= 1'b1;
    repeat (12) @(posedge clock_in);
    chk("masked event", 1, 32'(oe_n));
    bus(0, REG_STAT, 0);
    chk("floor loop sysmin", 32'h3, 32'(q[4:3]));
    // Enable low freezes everything, even an overcurrent
    ce_in <= 1'b0;
    p.batt_ocp <= 1'b1;
    repeat (8) @(posedge clock_in);
    chk("frozen switch", 1, 32'(bsw));
    ce_in <= 1'b1;
    repeat (8) @(posedge clock_in);
    chk("resumed trip", 0, 32'(bsw));
    complete_run();
  end
endmodule
